// ==== inc/reader_io_pkg.sv ====
// Constants and types for the reader discrete input and output conditioning.
// Assumes a 20 MHz system clock; all timing counts derive from it.
package reader_io_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ          = 20000000;

    // Debounce filter times, in ms as printed
    localparam int unsigned DEB_SHORT_MS    = 5;
    localparam int unsigned DEB_LONG_MS     = 500;
    // Debounce times in cycles: 100,000 and 10,000,000
    localparam int unsigned DEB_SHORT_CYC   = (CLK_HZ / 1000) * DEB_SHORT_MS;
    localparam int unsigned DEB_LONG_CYC    = (CLK_HZ / 1000) * DEB_LONG_MS;

    // Output filter delay, in us as printed
    localparam int unsigned OUT_FILT_US     = 50;
    localparam int unsigned OUT_FILT_CYC    = (CLK_HZ / 1000000) * OUT_FILT_US;

    // Width of debounce counters (holds 10,000,000)
    localparam int unsigned DEB_CNT_W       = 24;
    localparam int unsigned OUT_CNT_W       = 11;

    // Filter selection encoding
    localparam logic        FILT_SEL_SHORT  = 1'b0;
    localparam logic        FILT_SEL_LONG   = 1'b1;

    // Width of the expected code count
    localparam int unsigned EXP_CODES_W     = 4;

    // Reader events that may steer an event output
    typedef enum logic [1:0] {
        EV_NONE,
        EV_COMPLETE_READ,
        EV_NO_READ
    } event_sel_t;

    // Read cycle states
    typedef enum logic [1:0] {
        RC_IDLE,
        RC_ACTIVE,
        RC_DONE
    } read_state_t;

endpackage : reader_io_pkg

// ==== core/input_debounce.sv ====
// Three-flop synchroniser plus a stability debounce for one discrete input.
// Assumes the raw input is asynchronous to sys_clk.
`timescale 1ns/1ps
module input_debounce
    import reader_io_pkg::*;
#(
    parameter int unsigned SHORT_CYC = DEB_SHORT_CYC,
    parameter int unsigned LONG_CYC  = DEB_LONG_CYC
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // Raw input and filter choice
    input  wire logic raw_in,
    input  wire logic filt_sel,
    // Conditioned level
    output logic      filt_out
);
    logic [2:0]           sync_ff;
    logic [DEB_CNT_W-1:0] cnt_ff;
    logic [DEB_CNT_W-1:0] nxt_cnt;
    logic                 filt_ff;
    logic                 nxt_filt;
    logic [DEB_CNT_W-1:0] limit;
    logic                 settled;

    // Only the agreeing later stages are looked at
    assign settled = (sync_ff[1] == sync_ff[2]);

    always_comb
    begin
        limit    = (filt_sel == FILT_SEL_LONG) ? DEB_CNT_W'(LONG_CYC) : DEB_CNT_W'(SHORT_CYC);
        nxt_cnt  = cnt_ff;
        nxt_filt = filt_ff;
        // Any bounce back to the held level restarts the timing
        if (!settled || sync_ff[2] == filt_ff)
        begin
            nxt_cnt = '0;
        end
        else if (cnt_ff + DEB_CNT_W'(1) >= limit)
        begin
            nxt_cnt  = '0;
            nxt_filt = sync_ff[2];
        end
        else
        begin
            nxt_cnt = cnt_ff + DEB_CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sync_ff <= 3'h0;
            cnt_ff  <= '0;
            filt_ff <= 1'b0;
        end
        else
        begin
            sync_ff <= {sync_ff[1:0], raw_in};
            cnt_ff  <= nxt_cnt;
            filt_ff <= nxt_filt;
        end
    end

    assign filt_out = filt_ff;

endmodule : input_debounce

// ==== core/output_filter.sv ====
// Delays an event output control level by a fixed filter time.
// Assumes a synchronous control level from the same clock.
`timescale 1ns/1ps
module output_filter
    import reader_io_pkg::*;
#(
    parameter int unsigned DELAY_CYC = OUT_FILT_CYC
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic srst,
    // Control level in, delayed level out
    input  wire logic ctrl_in,
    output logic      pin_out
);
    logic [OUT_CNT_W-1:0] cnt_ff;
    logic [OUT_CNT_W-1:0] nxt_cnt;
    logic                 out_ff;
    logic                 nxt_out;

    // A change must persist for the whole delay, which also drops glitches
    always_comb
    begin
        nxt_cnt = '0;
        nxt_out = out_ff;
        if (ctrl_in != out_ff)
        begin
            if (cnt_ff + OUT_CNT_W'(1) >= OUT_CNT_W'(DELAY_CYC))
            begin
                nxt_out = ctrl_in;
            end
            else
            begin
                nxt_cnt = cnt_ff + OUT_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cnt_ff <= '0;
            out_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
        end
    end

    assign pin_out = out_ff;

endmodule : output_filter

// ==== core/reader_io_debounce_events.sv ====
// Discrete input conditioning and event output mapping for a code reader.
// Assumes one 20 MHz clock; the decoder reports codes and speed samples as pulses.
//
// Notes on behaviour
// - Inputs debounced, 5 ms or 500 ms
// - Trigger and stops share one filter
// - Encoder input has own 5 ms or 500 ms choice
// - Active trigger starts a read cycle
// - Trigger lamp follows trigger input
// - Enabled stop input ends read cycle
// - Encoder pulses measure belt speed
// - Each output maps any reader event
// - First output defaults to complete read
// - Complete read only after all codes
// - Second output defaults to no read
// - Third output defaults to none, holds
// - Outputs one and two delayed 50 us
`timescale 1ns/1ps
module reader_io_debounce_events
    import reader_io_pkg::*;
#(
    parameter int unsigned SHORT_CYC = DEB_SHORT_CYC,
    parameter int unsigned LONG_CYC  = DEB_LONG_CYC,
    parameter int unsigned OUT_CYC   = OUT_FILT_CYC,
    parameter int unsigned SPEED_W   = 16
)
(
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    // Raw discrete inputs
    input  wire logic                    presence_trigger_input,
    input  wire logic                    encoder_input,
    input  wire logic                    stop_input_a,
    input  wire logic                    stop_input_b,
    // Filter configuration
    input  wire logic                    trig_stop_filt_long,
    input  wire logic                    encoder_filt_long,
    // Read cycle configuration
    input  wire logic                    stop_a_en,
    input  wire logic                    stop_b_en,
    input  wire logic                    tracking_mode,
    input  wire logic [EXP_CODES_W-1:0]  expected_codes,
    // Event output mapping
    input  wire reader_io_pkg::event_sel_t first_sel,
    input  wire reader_io_pkg::event_sel_t second_sel,
    input  wire reader_io_pkg::event_sel_t third_sel,
    // Decoder results
    input  wire logic                    code_read_pulse,
    input  wire logic                    speed_sample_pulse,
    // Read cycle status, trigger lamp and belt speed
    output logic                         read_active,
    output logic                         read_start_pulse,
    output logic                         trigger_lamp,
    output logic [SPEED_W-1:0]           belt_speed,
    // Event outputs
    output logic                         first_event_output,
    output logic                         second_event_output,
    output logic                         third_event_output
);
    logic                   trig_f;
    logic                   enc_f;
    logic                   stop_a_f;
    logic                   stop_b_f;

    read_state_t            state_ff;
    read_state_t            nxt_state;
    logic                   trig_prev_ff;
    logic                   nxt_trig_prev;
    logic                   stop_a_prev_ff;
    logic                   nxt_stop_a_prev;
    logic                   stop_b_prev_ff;
    logic                   nxt_stop_b_prev;
    logic [EXP_CODES_W-1:0] got_ff;
    logic [EXP_CODES_W-1:0] nxt_got;
    logic                   complete_ff;
    logic                   nxt_complete;
    logic                   noread_ff;
    logic                   nxt_noread;
    logic                   start_ff;
    logic                   nxt_start;

    logic                   enc_prev_ff;
    logic                   nxt_enc_prev;
    logic [SPEED_W-1:0]     pulse_cnt_ff;
    logic [SPEED_W-1:0]     nxt_pulse_cnt;
    logic [SPEED_W-1:0]     speed_ff;
    logic [SPEED_W-1:0]     nxt_speed;

    logic                   ctrl1;
    logic                   ctrl2;
    logic                   third_ff;
    logic                   nxt_third;
    logic                   stop_hit;
    logic                   trig_rise;
    logic                   end_cycle;

    // Selected event level; EV_NONE yields the caller's hold value
    function automatic logic ev_level(input event_sel_t sel, input logic cur,
                                      input logic comp, input logic nord);
        logic r;
        r = cur;
        unique case (sel)
            EV_NONE:          r = cur;
            EV_COMPLETE_READ: r = comp;
            EV_NO_READ:       r = nord;
            default:          r = cur;
        endcase
        return r;
    endfunction : ev_level

    // Trigger and stops share one filter choice
    input_debounce #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_deb_trig (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .raw_in   (presence_trigger_input),
        .filt_sel (trig_stop_filt_long),
        .filt_out (trig_f)
    );
    input_debounce #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_deb_stop_a (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .raw_in   (stop_input_a),
        .filt_sel (trig_stop_filt_long),
        .filt_out (stop_a_f)
    );
    input_debounce #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_deb_stop_b (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .raw_in   (stop_input_b),
        .filt_sel (trig_stop_filt_long),
        .filt_out (stop_b_f)
    );
    // Encoder has its own choice; long setting with an encoder fitted
    input_debounce #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_deb_enc (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .raw_in   (encoder_input),
        .filt_sel (encoder_filt_long),
        .filt_out (enc_f)
    );

    assign trig_rise = trig_f && !trig_prev_ff;
    assign stop_hit  = (stop_a_en && stop_a_f && !stop_a_prev_ff)
                     || (stop_b_en && stop_b_f && !stop_b_prev_ff);
    // Trigger falling also ends the cycle
    assign end_cycle = stop_hit || !trig_f;

    // Read cycle control
    always_comb
    begin
        nxt_state       = state_ff;
        nxt_trig_prev   = trig_f;
        nxt_stop_a_prev = stop_a_f;
        nxt_stop_b_prev = stop_b_f;
        nxt_got         = got_ff;
        nxt_complete    = complete_ff;
        nxt_noread      = noread_ff;
        nxt_start       = 1'b0;
        unique case (state_ff)
            RC_IDLE:
            begin
                if (trig_rise)
                begin
                    nxt_state    = RC_ACTIVE;
                    nxt_start    = 1'b1;
                    nxt_got      = '0;
                    nxt_complete = 1'b0;
                    nxt_noread   = 1'b0;
                end
            end
            RC_ACTIVE:
            begin
                if (code_read_pulse && got_ff != expected_codes)
                begin
                    nxt_got = got_ff + EXP_CODES_W'(1);
                end
                // Zero expected codes treated as one
                if (code_read_pulse
                    && (got_ff + EXP_CODES_W'(1) >= expected_codes))
                begin
                    nxt_complete = 1'b1;
                    nxt_state    = RC_DONE;
                end
                else if (end_cycle)
                begin
                    nxt_noread = 1'b1;
                    nxt_state  = RC_DONE;
                end
            end
            RC_DONE:
            begin
                // Wait for trigger release before rearming
                if (!trig_f)
                begin
                    nxt_state = RC_IDLE;
                end
            end
            default:
            begin
                nxt_state = RC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_ff       <= RC_IDLE;
            trig_prev_ff   <= 1'b0;
            stop_a_prev_ff <= 1'b0;
            stop_b_prev_ff <= 1'b0;
            got_ff         <= '0;
            complete_ff    <= 1'b0;
            noread_ff      <= 1'b0;
            start_ff       <= 1'b0;
        end
        else
        begin
            state_ff       <= nxt_state;
            trig_prev_ff   <= nxt_trig_prev;
            stop_a_prev_ff <= nxt_stop_a_prev;
            stop_b_prev_ff <= nxt_stop_b_prev;
            got_ff         <= nxt_got;
            complete_ff    <= nxt_complete;
            noread_ff      <= nxt_noread;
            start_ff       <= nxt_start;
        end
    end

    // Belt speed: encoder edges counted between sample pulses
    always_comb
    begin
        nxt_enc_prev  = enc_f;
        nxt_pulse_cnt = pulse_cnt_ff;
        nxt_speed     = speed_ff;
        if (!tracking_mode)
        begin
            nxt_pulse_cnt = '0;
        end
        else if (speed_sample_pulse)
        begin
            nxt_speed     = pulse_cnt_ff;
            nxt_pulse_cnt = (enc_f && !enc_prev_ff) ? SPEED_W'(1) : '0;
        end
        else if (enc_f && !enc_prev_ff && pulse_cnt_ff != '1)
        begin
            nxt_pulse_cnt = pulse_cnt_ff + SPEED_W'(1);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            enc_prev_ff  <= 1'b0;
            pulse_cnt_ff <= '0;
            speed_ff     <= '0;
        end
        else
        begin
            enc_prev_ff  <= nxt_enc_prev;
            pulse_cnt_ff <= nxt_pulse_cnt;
            speed_ff     <= nxt_speed;
        end
    end

    // Event mapping; defaults come from the selection inputs
    always_comb
    begin
        ctrl1     = ev_level(first_sel, 1'b0, complete_ff, noread_ff);
        ctrl2     = ev_level(second_sel, 1'b0, complete_ff, noread_ff);
        nxt_third = ev_level(third_sel, third_ff, complete_ff, noread_ff);
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            third_ff <= 1'b0;
        end
        else
        begin
            third_ff <= nxt_third;
        end
    end

    output_filter #(.DELAY_CYC(OUT_CYC)) u_first_event_output (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ctrl_in (ctrl1),
        .pin_out (first_event_output)
    );
    output_filter #(.DELAY_CYC(OUT_CYC)) u_second_event_output (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ctrl_in (ctrl2),
        .pin_out (second_event_output)
    );

    assign third_event_output = third_ff;
    assign trigger_lamp       = trig_f;
    assign read_active        = (state_ff == RC_ACTIVE);
    assign read_start_pulse   = start_ff;
    assign belt_speed         = speed_ff;

endmodule : reader_io_debounce_events

// ==== verification/reader_io_monitor.sv ====
// Checker of the reader I/O block, bound to its top ports.
// Assumes filter choices stay steady while the trigger moves.
`timescale 1ns/1ps
module reader_io_monitor
    import reader_io_pkg::*;
#(
    parameter int unsigned SHORT_CYC = DEB_SHORT_CYC,
    parameter int unsigned LONG_CYC  = DEB_LONG_CYC,
    parameter int unsigned OUT_CYC   = OUT_FILT_CYC,
    parameter int unsigned SPEED_W   = 16
)
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    // Watched inputs
    input  wire logic                      presence_trigger_input,
    input  wire logic                      trig_stop_filt_long,
    input  wire logic                      speed_sample_pulse,
    input  wire reader_io_pkg::event_sel_t first_sel,
    input  wire reader_io_pkg::event_sel_t second_sel,
    input  wire reader_io_pkg::event_sel_t third_sel,
    // Watched outputs
    input  wire logic                      read_active,
    input  wire logic                      read_start_pulse,
    input  wire logic                      trigger_lamp,
    input  wire logic [SPEED_W-1:0]        belt_speed,
    input  wire logic                      first_event_output,
    input  wire logic                      second_event_output,
    input  wire logic                      third_event_output
);
    logic [23:0] hi_ff, lo_ff, idle_ff, nxt_hi, nxt_lo, nxt_idle;
    int unsigned flt;

    assign flt = trig_stop_filt_long ? LONG_CYC : SHORT_CYC;

    // Run lengths; no saturation, runs stay short in simulation
    always_comb
    begin
        nxt_hi   = presence_trigger_input ? hi_ff + 24'h1 : 24'h0;
        nxt_lo   = presence_trigger_input ? 24'h0 : lo_ff + 24'h1;
        nxt_idle = read_active ? 24'h0 : idle_ff + 24'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        hi_ff   <= srst ? 24'h0 : nxt_hi;
        lo_ff   <= srst ? 24'h0 : nxt_lo;
        idle_ff <= srst ? 24'h0 : nxt_idle;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_lamp_rise_stable: assert property ($rose(trigger_lamp) |-> hi_ff >= flt)
        else $error("lamp rose before trigger was stable");
    a_lamp_fall_stable: assert property ($fell(trigger_lamp) |-> lo_ff >= flt)
        else $error("lamp fell before trigger was stable low");
    a_start_pulse_follows: assert property ($rose(read_active) |-> ##[0:1] read_start_pulse)
        else $error("read cycle began without start pulse");
    a_start_needs_lamp: assert property (read_start_pulse |-> ##[0:1] trigger_lamp)
        else $error("read cycle began without active trigger");
    a_start_one_cycle: assert property (read_start_pulse |=> !read_start_pulse)
        else $error("start pulse longer than one cycle");
    a_first_event_output_filtered: assert property (($rose(first_event_output)
        && first_sel == EV_COMPLETE_READ) |-> idle_ff >= OUT_CYC - 1)
        else $error("first output rose before filter delay");
    a_second_event_output_filtered: assert property (($rose(second_event_output)
        && second_sel == EV_NO_READ) |-> idle_ff >= OUT_CYC - 1)
        else $error("second output rose before filter delay");
    a_third_none_holds: assert property ((third_sel == EV_NONE && $past(third_sel) == EV_NONE
        && $past(third_sel, 2) == EV_NONE) |-> $stable(third_event_output))
        else $error("third output moved with no event assigned");
    a_speed_on_sample: assert property ($changed(belt_speed)
        |-> $past(speed_sample_pulse) || $past(speed_sample_pulse, 2))
        else $error("belt speed changed without sample pulse");

    c_complete: cover property ($rose(first_event_output));
    c_no_read: cover property ($rose(second_event_output));
    c_speed: cover property ($changed(belt_speed));
endmodule : reader_io_monitor

bind reader_io_debounce_events reader_io_monitor #(
    .SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC), .OUT_CYC(OUT_CYC), .SPEED_W(SPEED_W)
) u_mon (
    .sys_clk(sys_clk), .srst(srst), .presence_trigger_input(presence_trigger_input),
    .trig_stop_filt_long(trig_stop_filt_long), .speed_sample_pulse(speed_sample_pulse),
    .first_sel(first_sel), .second_sel(second_sel), .third_sel(third_sel),
    .read_active(read_active), .read_start_pulse(read_start_pulse),
    .trigger_lamp(trigger_lamp), .belt_speed(belt_speed),
    .first_event_output(first_event_output), .second_event_output(second_event_output),
    .third_event_output(third_event_output)
);

// ==== verification/field_sensor_model.sv ====
// Photocells, encoder and stop sensors in front of the reader.
// Assumes the bench requests levels; chatter mimics contact bounce.
`timescale 1ns/1ps
module field_sensor_model
(
    // Clock
    input  wire logic sys_clk,
    // Requested levels and bounce
    input  wire logic trig_req,
    input  wire logic enc_req,
    input  wire logic stop_a_req,
    input  wire logic stop_b_req,
    input  wire logic chatter,
    // Raw lines to the reader
    output logic      trig_raw,
    output logic      enc_raw,
    output logic      stop_a_raw,
    output logic      stop_b_raw
);
    logic tgl_ff = 1'b0;

    // Plain always: the declaration initialiser would be a second writer
    always @(posedge sys_clk)
    begin
        tgl_ff <= ~tgl_ff;
    end

    // Bounce only on the trigger; it flips the level every cycle
    assign trig_raw   = trig_req ^ (chatter & tgl_ff);
    assign enc_raw    = enc_req;
    assign stop_a_raw = stop_a_req;
    assign stop_b_raw = stop_b_req;
endmodule : field_sensor_model

// ==== verification/reader_io_debounce_events_tb.sv ====
// Self-checking bench for the reader I/O block with shortened filters.
// Assumes field_sensor_model and the bound monitor are compiled alongside.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module reader_io_debounce_events_tb;
    import reader_io_pkg::*;
    localparam int unsigned SC = 20;
    localparam int unsigned LC = 50;
    localparam int unsigned OC = 5;
    logic sys_clk, srst, trig_req, enc_req, sa_req, sb_req, chatter;
    logic trig_raw, enc_raw, sa_raw, sb_raw, ts_long, enc_long, sa_en, sb_en, track;
    logic code_p, spd_p, read_active, start_p, trigger_lamp, o1, o2, o3;
    logic [3:0] exp_codes;
    logic [15:0] belt_speed;
    event_sel_t s1, s2, s3;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    field_sensor_model u_field (.sys_clk(sys_clk), .trig_req(trig_req), .enc_req(enc_req),
        .stop_a_req(sa_req), .stop_b_req(sb_req), .chatter(chatter), .trig_raw(trig_raw),
        .enc_raw(enc_raw), .stop_a_raw(sa_raw), .stop_b_raw(sb_raw));

    reader_io_debounce_events #(.SHORT_CYC(SC), .LONG_CYC(LC), .OUT_CYC(OC)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .presence_trigger_input(trig_raw),
        .encoder_input(enc_raw), .stop_input_a(sa_raw), .stop_input_b(sb_raw),
        .trig_stop_filt_long(ts_long), .encoder_filt_long(enc_long), .stop_a_en(sa_en),
        .stop_b_en(sb_en), .tracking_mode(track), .expected_codes(exp_codes),
        .first_sel(s1), .second_sel(s2), .third_sel(s3), .code_read_pulse(code_p),
        .speed_sample_pulse(spd_p), .read_active(read_active), .read_start_pulse(start_p),
        .trigger_lamp(trigger_lamp), .belt_speed(belt_speed), .first_event_output(o1),
        .second_event_output(o2), .third_event_output(o3));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            test_done();
        end
    end

    // Edges until the chosen output reaches lvl, bounded by lim
    task automatic wait_sig(input int sel, input logic lvl, input int lim);
        logic v;
        n = 0;
        forever
        begin
            @(posedge sys_clk);
            #1;
            case (sel)
                0: v = trigger_lamp;
                1: v = read_active;
                2: v = o1;
                3: v = o2;
                default: v = o3;
            endcase
            n++;
            if (v === lvl || n >= lim) break;
        end
    endtask : wait_sig

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : step

    task automatic code_pulse;
        @(posedge sys_clk) code_p <= 1'b1;
        @(posedge sys_clk) code_p <= 1'b0;
    endtask : code_pulse

    task automatic trig_on;
        @(posedge sys_clk) trig_req <= 1'b1;
        wait_sig(1, 1'b1, LC + 20);
    endtask : trig_on

    task automatic trig_off;
        @(posedge sys_clk) trig_req <= 1'b0;
        wait_sig(0, 1'b0, LC + 20);
    endtask : trig_off

    task automatic t_complete;
        @(posedge sys_clk) exp_codes <= 4'h2;
        chatter <= 1'b1;
        trig_req <= 1'b1;
        step(3 * SC);
        `CHK(trigger_lamp, 1'b0)
        chatter <= 1'b0;
        wait_sig(0, 1'b1, SC + 10);
        `CHK(trigger_lamp, 1'b1)
        `CHK(n > SC - 4, 1'b1)
        wait_sig(1, 1'b1, 4);
        `CHK(read_active, 1'b1)
        `CHK(start_p, 1'b1)
        code_pulse();
        step(OC + 4);
        `CHK(o1, 1'b0)
        code_pulse();
        wait_sig(2, 1'b1, OC + 6);
        `CHK(o1, 1'b1)
        `CHK(n >= OC, 1'b1)
        `CHK(o2, 1'b0)
        trig_off();
        `CHK(trigger_lamp, 1'b0)
    endtask : t_complete

    task automatic t_stop(input logic use_b, input logic long_f);
        int flt;
        flt = long_f ? LC : SC;
        @(posedge sys_clk) ts_long <= long_f;
        sa_en <= !use_b;
        sb_en <= use_b;
        exp_codes <= 4'h1;
        trig_req <= 1'b1;
        wait_sig(0, 1'b1, LC + 20);
        `CHK(n > flt - 4 && n <= flt + 6, 1'b1)
        wait_sig(1, 1'b1, 4);
        @(posedge sys_clk) sa_req <= !use_b;
        sb_req <= use_b;
        wait_sig(1, 1'b0, LC + 20);
        `CHK(read_active, 1'b0)
        `CHK(n > flt - 4, 1'b1)
        wait_sig(3, 1'b1, OC + 8);
        `CHK(o2, 1'b1)
        `CHK(o1, 1'b0)
        @(posedge sys_clk) sa_req <= 1'b0;
        sb_req <= 1'b0;
        trig_off();
        step(flt + 8);
    endtask : t_stop

    task automatic t_map;
        @(posedge sys_clk) s1 <= EV_NO_READ;
        s2 <= EV_COMPLETE_READ;
        s3 <= EV_COMPLETE_READ;
        ts_long <= 1'b0;
        trig_on();
        code_pulse();
        wait_sig(3, 1'b1, OC + 8);
        `CHK({o1, o2, o3}, 3'b011)
        @(posedge sys_clk) s3 <= EV_NONE;
        trig_off();
        trig_on();
        trig_off();
        step(OC + 6);
        `CHK({o1, o3}, 2'b11)
        @(posedge sys_clk) s1 <= EV_COMPLETE_READ;
        s2 <= EV_NO_READ;
    endtask : t_map

    // Mid-run reset must clear the held third output as well
    task automatic t_reset;
        @(posedge sys_clk) srst <= 1'b1;
        step(3);
        srst <= 1'b0;
        step(2);
        `CHK({o1, o2, o3, trigger_lamp, read_active}, 5'h00)
    endtask : t_reset

    task automatic enc_pulse(input int w);
        @(posedge sys_clk) enc_req <= 1'b1;
        step(w);
        enc_req <= 1'b0;
        step(LC + 10);
    endtask : enc_pulse

    task automatic t_speed;
        @(posedge sys_clk) track <= 1'b1;
        enc_long <= 1'b1;
        spd_p <= 1'b1;
        @(posedge sys_clk) spd_p <= 1'b0;
        enc_pulse(SC + 5);
        repeat (3) enc_pulse(LC + 10);
        @(posedge sys_clk) spd_p <= 1'b1;
        @(posedge sys_clk) spd_p <= 1'b0;
        step(3);
        `CHK(belt_speed, 16'h0003)
    endtask : t_speed

    initial
    begin
        srst = 1'b1;
        {trig_req, enc_req, sa_req, sb_req, chatter, code_p, spd_p} = 7'h00;
        {ts_long, enc_long, sa_en, sb_en, track} = 5'h00;
        exp_codes = 4'h1;
        s1 = EV_COMPLETE_READ;
        s2 = EV_NO_READ;
        s3 = EV_NONE;
        step(10);
        srst <= 1'b0;
        step(2);
        `CHK({o1, o2, o3, read_active}, 4'h0)
        t_complete();
        t_stop(1'b0, 1'b0);
        t_stop(1'b1, 1'b1);
        t_map();
        t_reset();
        t_speed();
        test_done();
    end
endmodule : reader_io_debounce_events_tb
